// File: rtl/pao_adc_port.v
// pipelined converter digital core: stage decisions, error correction, output latch
`include "pao_defines.vh"
module pao_adc_port #(
   parameter WORD_W = `PAO_WORD_W,
   parameter STAGES = `PAO_STAGES,
   parameter LATENCY = `PAO_LATENCY
) (
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire [2*`PAO_STAGES-1:0] stage_dec_i,
   input wire output_float_i,
   input wire power_off_ctl_i,
   input wire ref_level_grounded_i,
   output wire [`PAO_WORD_W-1:0] sample_word_out_o,
   output wire [`PAO_WORD_W-1:0] sample_word_out_oe_o,
   output wire sample_bit_lowest_o,
   output wire sample_bit_highest_o,
   output wire sample_valid_o,
   output wire converting_o,
   output wire ref_buffers_on_o,
   output wire ref_nodes_oe_o
);
   ////////////////////////////////////////////////////////////////////////////
   // stage decisions come from the analog quantizers, another domain
   // each stage has its own two-flop chain on its 2-bit decision; only the second flop is read
   wire [2*`PAO_STAGES-1:0] dec_sync_w;
   genvar s;
   generate
      for (s = 0; s < `PAO_STAGES; s = s + 1) begin : dsync
         reg [1:0] meta_r;
         reg [1:0] sync_r;
         always @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               meta_r <= 2'h0;
               sync_r <= 2'h0;
            end else begin
               meta_r <= stage_dec_i[2*s+1 -: 2];
               sync_r <= meta_r;
            end
         end
         assign dec_sync_w[2*s+1 -: 2] = sync_r;
      end
   endgenerate

   // code 3 never comes from a healthy flash; it counts as a zero decision
   wire [2*`PAO_STAGES-1:0] dec_norm;
   generate
      for (s = 0; s < `PAO_STAGES; s = s + 1) begin : dnorm
         wire [1:0] raw;
         assign raw = dec_sync_w[2*s+1 -: 2];
         assign dec_norm[2*s+1 -: 2] = (raw == 2'h3) ? `PAO_DEC_ZERO : raw;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // control levels are asynchronous pins, two flops each
   // float resets high so the lines stay released until the first clocks
   reg float_meta_r;
   reg float_sync_r;
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         float_meta_r <= 1'b1;
         float_sync_r <= 1'b1;
      end else begin
         float_meta_r <= output_float_i;
         float_sync_r <= float_meta_r;
      end
   end

   reg off_meta_r;
   reg off_sync_r;
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         off_meta_r <= 1'b0;
         off_sync_r <= 1'b0;
      end else begin
         off_meta_r <= power_off_ctl_i;
         off_sync_r <= off_meta_r;
      end
   end

   reg refg_meta_r;
   reg refg_sync_r;
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         refg_meta_r <= 1'b0;
         refg_sync_r <= 1'b0;
      end else begin
         refg_meta_r <= ref_level_grounded_i;
         refg_sync_r <= refg_meta_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sample capture on the rising edge; shutdown halts the whole pipeline
   wire run;
   assign run = ~off_sync_r;
   reg [2*`PAO_STAGES-1:0] samp_r;
   reg samp_v_r;
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         samp_r <= {(2*`PAO_STAGES){1'b0}};
      end else if (run) begin
         samp_r <= dec_norm;
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         samp_v_r <= 1'b0;
      end else if (run) begin
         samp_v_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // twelve stages: ten at two per clock level over five levels, each pair resolved combinationally in one cycle; the last two are folded in ahead of the latch
   // total: capture + 5 stage levels + output latch = seven clocks
   localparam LEVELS = LATENCY - 2;
   reg [`PAO_ACC_W-1:0] acc_r [0:LEVELS-1];
   reg [2*`PAO_STAGES-1:0] dly_r [0:LEVELS-1];
   reg [LEVELS-1:0] v_r;

   // each stage gives -1/0/+1 from its 2-bit flash; weight halves per stage
   function [`PAO_ACC_W-1:0] stage_add;
      input [`PAO_ACC_W-1:0] acc;
      input [1:0] dec;
      input integer idx;
      reg [`PAO_ACC_W-1:0] w;
      begin
         w = {{(`PAO_ACC_W-1){1'b0}}, 1'b1} << (`PAO_STAGES - 1 - idx);
         case (dec)
            `PAO_DEC_PLUS: begin
               stage_add = acc + w;
            end
            `PAO_DEC_MINUS: begin
               stage_add = acc - w;
            end
            default: begin
               stage_add = acc;
            end
         endcase
      end
   endfunction

   genvar g;
   generate
      for (g = 0; g < LEVELS; g = g + 1) begin : lvl
         wire [`PAO_ACC_W-1:0] acc_in;
         wire [2*`PAO_STAGES-1:0] dec_in;
         wire v_in;
         wire [`PAO_ACC_W-1:0] half;
         wire [`PAO_ACC_W-1:0] full;
         if (g == 0) begin : first
            assign acc_in = {{(`PAO_ACC_W-`PAO_WORD_W){1'b0}}, `PAO_WORD_RST};
            assign dec_in = samp_r;
            assign v_in = samp_v_r;
         end else begin : rest
            assign acc_in = acc_r[g-1];
            assign dec_in = dly_r[g-1];
            assign v_in = v_r[g-1];
         end
         // two stages per clock level, levels beyond the last stage pass through
         assign half = (2*g < STAGES) ? stage_add(acc_in, dec_in[4*g+1 -: 2], 2*g) : acc_in;
         assign full = (2*g+1 < STAGES) ? stage_add(half, dec_in[4*g+3 -: 2], 2*g+1) : half;

         // partial sum of this level
         always @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               acc_r[g] <= {`PAO_ACC_W{1'b0}};
            end else if (run) begin
               acc_r[g] <= full;
            end
         end

         // decisions travel with their sample so later stages see the same set
         always @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               dly_r[g] <= {(2*`PAO_STAGES){1'b0}};
            end else if (run) begin
               dly_r[g] <= dec_in;
            end
         end

         always @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
               v_r[g] <= 1'b0;
            end else if (run) begin
               v_r[g] <= v_in;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // final stages not yet absorbed are folded in just ahead of the latch
   reg [`PAO_ACC_W-1:0] fin;
   integer k;
   always @* begin
      fin = acc_r[LEVELS-1];
      for (k = 2*LEVELS; k < STAGES; k = k + 1) begin
         fin = stage_add(fin, dly_r[LEVELS-1][2*k+1 -: 2], k);
      end
   end

   // error correction: the redundant sum may leave the code range, clamp it
   // a negative sum wraps into the top bit, so it is tested first
   reg [`PAO_WORD_W-1:0] corr_word;
   always @* begin
      corr_word = fin[`PAO_WORD_W-1:0];
      if (fin[`PAO_ACC_W-1]) begin
         corr_word = {`PAO_WORD_W{1'b0}};
      end else if (fin[`PAO_ACC_W-2:`PAO_WORD_W] != {(`PAO_ACC_W-1-`PAO_WORD_W){1'b0}}) begin
         corr_word = {`PAO_WORD_W{1'b1}};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output latch: holds during shutdown so the last word stays on the bus
   reg [`PAO_WORD_W-1:0] word_r;
   reg valid_r;
   reg oe_r;
   reg refbuf_r;
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         word_r <= `PAO_WORD_RST;
      end else if (run) begin
         word_r <= corr_word;
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         valid_r <= 1'b0;
      end else if (run) begin
         valid_r <= v_r[LEVELS-1];
      end
   end

   // enable follows the float level even in shutdown, latch stays frozen
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         oe_r <= 1'b0;
      end else begin
         oe_r <= ~float_sync_r;
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         refbuf_r <= 1'b1;
      end else begin
         refbuf_r <= ~refg_sync_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins
   assign sample_word_out_o = word_r;
   assign sample_word_out_oe_o = {`PAO_WORD_W{oe_r}};
   assign sample_bit_lowest_o = word_r[0];
   assign sample_bit_highest_o = word_r[`PAO_WORD_W-1];
   assign sample_valid_o = valid_r & oe_r;
   assign converting_o = run;
   assign ref_buffers_on_o = refbuf_r;
   assign ref_nodes_oe_o = refbuf_r;
endmodule

// File: rtl/pao_defines.vh
// constants for the pipelined converter output port
`ifndef PAO_DEFINES_VH
`define PAO_DEFINES_VH
`define PAO_WORD_W 12
`define PAO_STAGES 12
`define PAO_LATENCY 7
`define PAO_ACC_W 14
`define PAO_CLK_MIN_KHZ 100
`define PAO_CLK_MAX_KHZ 20000
`define PAO_WORD_RST 12'h0800
`define PAO_DEC_MINUS 2'h0
`define PAO_DEC_ZERO 2'h1
`define PAO_DEC_PLUS 2'h2
`endif

// File: verification/pao_port_checker.sv
// assertions on the converter output port
module pao_port_checker (
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire [23:0] stage_dec_i,
   input wire output_float_i,
   input wire power_off_ctl_i,
   input wire ref_level_grounded_i,
   input wire [11:0] sample_word_out_o,
   input wire [11:0] sample_word_out_oe_o,
   input wire sample_bit_lowest_o,
   input wire sample_bit_highest_o,
   input wire sample_valid_o,
   input wire converting_o,
   input wire ref_buffers_on_o,
   input wire ref_nodes_oe_o
);
   timeunit 1ns / 1ps;
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   logic [3:0] run_r;
   //////////////////////////////////////////
   // run length without shutdown, so latency is only judged on a full pipeline
   always @(posedge clk_sys_i or negedge rst_n_i)
      if (!rst_n_i) run_r <= 4'h0;
      else if (power_off_ctl_i) run_r <= 4'h0;
      else if (run_r != 4'hf) run_r <= run_r + 4'h1;
   function automatic int code_of(input logic [23:0] d);
      code_of = 2048;
      for (int s = 0; s < 12; s++) code_of += (d[2*s+:2] == 2'h2) - (d[2*s+:2] == 2'h0) << 11 - s;
      if (code_of < 0) code_of = 0;
      if (code_of > 4095) code_of = 4095;
   endfunction
   a_float_off: assert property (output_float_i[*3] |=> sample_word_out_oe_o == 12'h000) else $error("oe on");
   a_float_on: assert property ((!output_float_i)[*3] |=> sample_word_out_oe_o == 12'hfff) else $error("oe off");
   a_bit_order: assert property (sample_bit_lowest_o == sample_word_out_o[0]
      && sample_bit_highest_o == sample_word_out_o[11]) else $error("bit order");
   a_word_latency: assert property (run_r > 4'hb |-> sample_word_out_o == code_of($past(stage_dec_i, 9)))
      else $error("word");
   a_shut_enter: assert property ($rose(power_off_ctl_i) |-> ##[1:3] !converting_o) else $error("no stop");
   a_shut_hold: assert property ((!converting_o)[*2] |=> $stable(sample_word_out_o)) else $error("moved");
   a_ref_off: assert property (ref_level_grounded_i[*3] |=> !ref_buffers_on_o && !ref_nodes_oe_o) else $error("ref");
   a_ref_on: assert property ((!ref_level_grounded_i)[*3] |=> ref_buffers_on_o) else $error("ref on");
   a_valid_float: assert property (output_float_i[*3] |=> !sample_valid_o) else $error("valid");
   c_float: cover property (output_float_i[*3]);
   c_shut: cover property ((!converting_o)[*2]);
   c_stream: cover property (run_r > 4'hb && sample_valid_o);
   c_ref: cover property (!ref_buffers_on_o);
endmodule
bind pao_adc_port pao_port_checker i_pao_port_checker (.*);

// File: verification/pao_cap_model.sv
// downstream capture of the three-state word bus
module pao_cap_model (
   input wire clk_sys_i,
   input wire [11:0] word_i,
   input wire [11:0] oe_i,
   output logic [11:0] cap_o
);
   timeunit 1ns / 1ps;
   // released lines toggle against the last capture, so a stale word cannot pass
   wire [11:0] bus = (word_i & oe_i) | (~cap_o & ~oe_i);
   always @(posedge clk_sys_i) cap_o <= bus;
endmodule

// File: verification/tb_top.sv
// self-checking bench for the converter output port
module tb_top;
   timeunit 1ns / 1ps;
   logic clk_sys_i = 1'b0, rst_n_i = 1'b0, output_float_i = 1'b0, power_off_ctl_i = 1'b0;
   logic ref_level_grounded_i = 1'b0, sample_bit_lowest_o, sample_bit_highest_o, sample_valid_o;
   logic converting_o, ref_buffers_on_o, ref_nodes_oe_o;
   logic [23:0] stage_dec_i = 24'h55_5555;
   logic [11:0] sample_word_out_o, sample_word_out_oe_o, cap;
   int failures = 0, cmp_count = 0;
   always #4 clk_sys_i = ~clk_sys_i;
   pao_adc_port i_pao_adc_port (.*);
   pao_cap_model i_pao_cap_model (.clk_sys_i, .word_i(sample_word_out_o), .oe_i(sample_word_out_oe_o), .cap_o(cap));
   //////////////////////////////////////////
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask
   task automatic t_stream;
      logic [23:0] d[8] = '{24'h00_0000, 24'haa_aaaa, 24'h55_5555, 24'h95_5555, 24'h55_5552, 24'hff_ffff,
         24'h55_5556, 24'h00_0000};
      logic [11:0] e[8] = '{12'h000, 12'hfff, 12'h800, 12'h801, 12'hc00, 12'h800, 12'hfff, 12'h000};
      for (int i = 0; i < 18; i++) begin
         tick(1);
         if (i < 8) stage_dec_i <= d[i];
         if (i > 9) chk("word", e[i-10], sample_word_out_o);
         if (i > 9) chk("lsb", {11'h000, e[i-10][0]}, {11'h000, sample_bit_lowest_o});
         if (i > 9) chk("msb", {11'h000, e[i-10][11]}, {11'h000, sample_bit_highest_o});
      end
      $display("stream done");
   endtask
   task automatic t_float;
      output_float_i <= 1'b1;
      tick(4);
      chk("oe", 12'h000, sample_word_out_oe_o);
      chk("valid", 12'h000, {11'h000, sample_valid_o});
      output_float_i <= 1'b0;
      tick(5);
      chk("oe", 12'hfff, sample_word_out_oe_o);
      chk("valid", 12'h001, {11'h000, sample_valid_o});
      chk("bus", 12'h000, cap);
      $display("float done");
   endtask
   task automatic t_shut;
      stage_dec_i <= 24'h95_5555;
      tick(12);
      power_off_ctl_i <= 1'b1;
      stage_dec_i <= 24'h55_5552;
      tick(14);
      chk("run", 12'h000, {11'h000, converting_o});
      chk("held", 12'h801, sample_word_out_o);
      power_off_ctl_i <= 1'b0;
      tick(14);
      chk("wake", 12'hc00, sample_word_out_o);
      $display("shutdown done");
   endtask
   task automatic t_ref;
      ref_level_grounded_i <= 1'b1;
      tick(4);
      chk("ref", 12'h000, {10'h000, ref_buffers_on_o, ref_nodes_oe_o});
      ref_level_grounded_i <= 1'b0;
      tick(4);
      chk("ref", 12'h003, {10'h000, ref_buffers_on_o, ref_nodes_oe_o});
      $display("reference done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      tick(5);
      rst_n_i <= 1'b1;
      tick(3);
      t_stream();
      t_float();
      t_shut();
      t_ref();
      final_report();
   end
   // whole run needs about 83 cycles
   initial begin
      tick(400);
      failures++;
      final_report();
   end
endmodule
